// ---- rtl/spc_top.v ----
// serializer pin control: pixel port, general outputs, strap, control bus pins
//
// Implementation choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "spc_defines.vh"
module spc_top (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // parallel pixel port
  input  wire        pixel_clock,
  input  wire [11:0] pixel_data,
  input  wire        hsync,
  input  wire        vsync,
  // remote deserializer input levels
  input  wire [3:0]  remote_gpio,
  // general purpose pins
  output reg  [2:0]  general_output_pin,
  input  wire        gpo3_in,
  output reg         gpo3_out,
  output reg         gpo3_oe,
  // control bus pins, open drain
  input  wire        scl_in,
  output wire        scl_out,
  output wire        scl_oe,
  input  wire        sda_in,
  output wire        sda_out,
  output reg         sda_oe,
  // strap and power
  input  wire [2:0]  address_strap_pin,
  input  wire        power_down_n,
  output reg         pll_enable,
  // captured pixel word
  output wire [13:0] pixel_word,
  output wire        pixel_strobe
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  wire [`SPC_PIX_W-1:0]   pix_s;
  wire                    pix_clk_s;
  wire [3:0]              remote_s;
  wire                    osc_in_s;
  wire                    scl_s;
  wire                    sda_s;
  wire [`SPC_STRAP_W-1:0] strap_s;
  wire                    pdn_s;

  spc_sync #(.W(`SPC_PIX_W + 1)) u_sync_pix (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({pixel_clock, vsync, hsync, pixel_data}),
    .sync_out ({pix_clk_s, pix_s})
  );

  spc_sync #(.W(4 + 1 + 2 + `SPC_STRAP_W + 1)) u_sync_misc (
    .clk      (pclk),
    .rst_n    (presetn),
    .async_in ({remote_gpio, gpo3_in, scl_in, sda_in, address_strap_pin, power_down_n}),
    .sync_out ({remote_s, osc_in_s, scl_s, sda_s, strap_s, pdn_s})
  );

  // ----------------------------------------
  // power state
  // ----------------------------------------
  wire powered;
  assign powered = pdn_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_enable <= 1'b0;
    end else begin
      pll_enable <= powered;  // [R6]
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  reg                       edge_sel;
  reg [`SPC_GPO_CFG_W-1:0]  gpo_cfg;
  wire                      wr_en;
  wire                      rd_en;
  wire                      addr_hit;

  assign pready   = 1'b1;
  assign wr_en    = psel & penable & pwrite;
  assign rd_en    = psel & penable & ~pwrite;
  assign addr_hit = (paddr == `SPC_ADDR_CTRL) || (paddr == `SPC_ADDR_GPO_CFG) ||
                    (paddr == `SPC_ADDR_STATUS) || (paddr == `SPC_ADDR_PIXEL);
  assign pslverr  = psel & penable & ~addr_hit;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_sel <= `SPC_CTRL_RST;
      gpo_cfg  <= `SPC_GPO_CFG_RST;
    end else if (!powered) begin
      // programmed contents are not kept across power-down
      edge_sel <= `SPC_CTRL_RST;  // [R7]
      gpo_cfg  <= `SPC_GPO_CFG_RST;  // [R7]
    end else if (wr_en) begin
      if (paddr == `SPC_ADDR_CTRL) begin
        edge_sel <= pwdata[`SPC_CTRL_EDGE_BIT];  // [R1]
      end else if (paddr == `SPC_ADDR_GPO_CFG) begin
        gpo_cfg <= pwdata[`SPC_GPO_CFG_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // pixel capture
  // ----------------------------------------
  spc_pixel_capture u_capture (
    .clk        (pclk),
    .rst_n      (presetn),
    .enable     (powered),  // [R6]
    .edge_sel   (edge_sel),
    .pix_clk_s  (pix_clk_s),
    .pix_in_s   (pix_s),
    .pix_word   (pixel_word),
    .pix_strobe (pixel_strobe)
  );

  // ----------------------------------------
  // oscillator clock out divider
  // ----------------------------------------
  reg [`SPC_OSC_CNT_W-1:0] osc_cnt;
  reg                      osc_level;
  wire                     osc_tick;

  assign osc_tick = (osc_cnt == `SPC_OSC_HALF_CYC - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_cnt   <= {`SPC_OSC_CNT_W{1'b0}};
      osc_level <= 1'b0;
    end else if (!powered) begin
      // divider held still in power-down to save activity
      osc_cnt   <= {`SPC_OSC_CNT_W{1'b0}};  // [R6]
      osc_level <= 1'b0;
    end else if (osc_tick) begin
      osc_cnt   <= {`SPC_OSC_CNT_W{1'b0}};
      osc_level <= ~osc_level;
    end else begin
      osc_cnt <= osc_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // general purpose outputs
  // ----------------------------------------
  wire [1:0] pin_mode [0:3];
  wire [3:0] pin_local;
  reg  [2:0] next_gpo;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cfg
      assign pin_mode[gi]  = gpo_cfg[gi*`SPC_GPO_FLD_W +: 2];
      assign pin_local[gi] = gpo_cfg[gi*`SPC_GPO_FLD_W + `SPC_GPO_VAL_BIT];
    end
  endgenerate

  integer k;
  always @* begin
    next_gpo = 3'h0;
    for (k = 0; k < 2; k = k + 1) begin
      if (pin_mode[k] == `SPC_MODE_LOCAL) begin
        next_gpo[k] = pin_local[k];  // [R2]
      end else begin
        next_gpo[k] = remote_s[k];  // [R2]
      end
    end
    if (pin_mode[2] == `SPC_MODE_OSC) begin
      next_gpo[2] = osc_level;  // [R3]
    end else if (pin_mode[2] == `SPC_MODE_LOCAL) begin
      next_gpo[2] = pin_local[2];  // [R3]
    end else begin
      next_gpo[2] = remote_s[2];  // [R3]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      general_output_pin <= 3'h0;
      gpo3_out           <= 1'b0;
      gpo3_oe            <= 1'b0;
    end else begin
      general_output_pin <= powered ? next_gpo : 3'h0;
      if (!powered || pin_mode[3] == `SPC_MODE_OSC) begin
        // pin becomes the oscillator clock input
        gpo3_oe  <= 1'b0;  // [R4]
        gpo3_out <= 1'b0;
      end else if (pin_mode[3] == `SPC_MODE_LOCAL) begin
        gpo3_oe  <= 1'b1;
        gpo3_out <= pin_local[3];  // [R4]
      end else begin
        gpo3_oe  <= 1'b1;
        gpo3_out <= remote_s[3];  // [R4]
      end
    end
  end

  // ----------------------------------------
  // device address from strap
  // ----------------------------------------
  reg [`SPC_DEV_ADDR_W-1:0] dev_addr;
  reg                       strap_taken;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dev_addr    <= `SPC_DEV_ADDR_BASE;
      strap_taken <= 1'b0;
    end else if (!powered) begin
      strap_taken <= 1'b0;
    end else if (!strap_taken) begin
      // sampled once per power-up; the divider level is static
      dev_addr    <= `SPC_DEV_ADDR_BASE + {{(`SPC_DEV_ADDR_W-`SPC_STRAP_W){1'b0}}, strap_s};  // [R5]
      strap_taken <= 1'b1;
    end
  end

  // ----------------------------------------
  // control bus target: address match and acknowledge
  // ----------------------------------------
  localparam ST_IDLE = 3'b001;
  localparam ST_ADDR = 3'b010;
  localparam ST_ACK  = 3'b100;

  reg [2:0] state;
  reg       scl_d;
  reg       sda_d;
  reg [7:0] shift;
  reg [3:0] bit_cnt;
  reg       addr_match;
  wire      scl_rise;
  wire      scl_fall;
  wire      start_seen;
  wire      stop_seen;

  // lines are never driven high, only released
  assign scl_out    = 1'b0;  // [R8]
  assign scl_oe     = 1'b0;
  assign sda_out    = 1'b0;  // [R8]
  assign scl_rise   = scl_s & ~scl_d;
  assign scl_fall   = ~scl_s & scl_d;
  assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_seen  = scl_s & scl_d & ~sda_d & sda_s;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state      <= ST_IDLE;
      scl_d      <= 1'b1;
      sda_d      <= 1'b1;
      shift      <= 8'h00;
      bit_cnt    <= 4'h0;
      sda_oe     <= 1'b0;
      addr_match <= 1'b0;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      if (!powered || stop_seen) begin
        state  <= ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_seen) begin
        state   <= ST_ADDR;
        bit_cnt <= 4'h0;
        sda_oe  <= 1'b0;
      end else begin
        case (state)
          ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 1'b1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (shift[7:1] == dev_addr) begin
                sda_oe     <= 1'b1;  // [R5] [R8]
                addr_match <= 1'b1;
                state      <= ST_ACK;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;  // [R8]
              state  <= ST_IDLE;
            end
          end
          default: begin
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // read data
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      // registered in setup so data is ready in the access phase
      if (paddr == `SPC_ADDR_CTRL) begin
        prdata <= {31'h0, edge_sel};
      end else if (paddr == `SPC_ADDR_GPO_CFG) begin
        prdata <= {16'h0000, gpo_cfg};
      end else if (paddr == `SPC_ADDR_STATUS) begin
        prdata <= {22'h0, addr_match, osc_in_s, dev_addr, pll_enable};
      end else if (paddr == `SPC_ADDR_PIXEL) begin
        prdata <= {18'h0, pixel_word};
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule // spc_top

// ---- rtl/spc_defines.vh ----
// constants for the serializer pin control block
// What this block does, and what it assumes of the imager
// (R1) Pixel inputs strobed on software-selected clock edge
// (R2) Outputs 0,1 mirror remote input or local bit
// (R3) Output 2: remote, local, or oscillator clock out
// (R4) Pin 3: remote, local, or oscillator clock in
// (R5) Control bus address taken from strap pin level
// (R6) Power-down low stops PLL, minimises activity
// (R7) Power-down returns control registers to defaults
// (R8) Control bus lines only pulled low, open-drain
// (R9) Imager holds pixel bits stable around strobe
`ifndef SPC_DEFINES_VH
`define SPC_DEFINES_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SPC_ADDR_CTRL      8'h00
`define SPC_ADDR_GPO_CFG   8'h04
`define SPC_ADDR_STATUS    8'h08
`define SPC_ADDR_PIXEL     8'h0C
`define SPC_ADDR_MSB       7

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define SPC_CTRL_EDGE_BIT  0
`define SPC_CTRL_RST       1'h0
`define SPC_GPO_CFG_RST    16'h0000
`define SPC_GPO_CFG_W      16
`define SPC_GPO_FLD_W      4
`define SPC_GPO_VAL_BIT    2
`define SPC_MODE_REMOTE    2'h0
`define SPC_MODE_LOCAL     2'h1
`define SPC_MODE_OSC       2'h2
`define SPC_PIX_W          14
`define SPC_STRAP_W        3
`define SPC_DEV_ADDR_W     7
`define SPC_DEV_ADDR_BASE  7'h58

// ----------------------------------------
// timing
// ----------------------------------------
`define SPC_CLK_PERIOD_NS  10
`define SPC_OSC_HALF_NS    40
`define SPC_OSC_HALF_CYC   (`SPC_OSC_HALF_NS / `SPC_CLK_PERIOD_NS)
`define SPC_OSC_CNT_W      3

`endif

// ---- rtl/spc_sync.v ----
// two-flop synchroniser for a group of outside levels
`timescale 1ns/10ps
module spc_sync #(
  parameter W = 1
) (
  // clock and reset
  input  wire         clk,
  input  wire         rst_n,
  // levels
  input  wire [W-1:0] async_in,
  output reg  [W-1:0] sync_out
);

  reg [W-1:0] meta;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta     <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule // spc_sync

// ---- rtl/spc_pixel_capture.v ----
// pixel port capture on the selected pixel clock edge
`timescale 1ns/10ps
`include "spc_defines.vh"
module spc_pixel_capture (
  // clock and reset
  input  wire                   clk,
  input  wire                   rst_n,
  // control
  input  wire                   enable,
  input  wire                   edge_sel,
  // synchronised pixel port
  input  wire                   pix_clk_s,
  input  wire [`SPC_PIX_W-1:0]  pix_in_s,
  // captured word
  output reg  [`SPC_PIX_W-1:0]  pix_word,
  output reg                    pix_strobe
);

  reg  pix_clk_d;
  wire rise_seen;
  wire fall_seen;
  wire take;

  assign rise_seen = pix_clk_s & ~pix_clk_d;
  assign fall_seen = ~pix_clk_s & pix_clk_d;
  // 1 selects the falling edge
  assign take = enable & (edge_sel ? fall_seen : rise_seen);  // [R1]

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_clk_d  <= 1'b0;
      pix_word   <= {`SPC_PIX_W{1'b0}};
      pix_strobe <= 1'b0;
    end else begin
      pix_clk_d  <= pix_clk_s;
      pix_strobe <= take;
      // data and clock share synchroniser depth, so the word stays aligned
      if (take) begin
        pix_word <= pix_in_s;  // [R1] [R9]
      end
    end
  end

endmodule // spc_pixel_capture

// ---- tb/spc_properties.sv ----
// port assertions for the serializer pin control block
`timescale 1ns/10ps
module spc_properties (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // pins
  input wire logic [2:0] general_output_pin,
  input wire logic       gpo3_oe,
  input wire logic       scl_in,
  input wire logic       scl_out,
  input wire logic       scl_oe,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       power_down_n,
  input wire logic       pll_enable,
  input wire logic       pixel_strobe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // two sync flops plus one clear edge, then the edge that samples it; no cycle spare
  sequence pd_held;
    !power_down_n [*4];
  endsequence
  scl_free_a: assert property (!scl_oe && !scl_out)
    else $error("scl driven");
  sda_low_a: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  ack_scl_low_a: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("ack raised while scl high");
  pll_stop_a: assert property (pd_held |-> !pll_enable)
    else $error("pll runs in power down");
  pd_pins_a: assert property (pd_held |-> general_output_pin == 3'h0 && !gpo3_oe)
    else $error("outputs active in power down");
  pd_pixel_a: assert property (pd_held |-> !pixel_strobe)
    else $error("pixel captured in power down");
  pll_run_a: assert property (power_down_n [*8] |-> pll_enable)
    else $error("pll stopped while powered");
  strobe_pulse_a: assert property (pixel_strobe |=> !pixel_strobe)
    else $error("strobe longer than one cycle");
  slverr_phase_a: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access");
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("access not answered");
endmodule // spc_properties

bind spc_top spc_properties u_spc_properties (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready),
  .pslverr(pslverr), .general_output_pin(general_output_pin), .gpo3_oe(gpo3_oe),
  .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe), .sda_out(sda_out),
  .sda_oe(sda_oe), .power_down_n(power_down_n), .pll_enable(pll_enable),
  .pixel_strobe(pixel_strobe));

// ---- tb/spc_imager.sv ----
// imager model driving the parallel pixel port
`timescale 1ns/10ps
module spc_imager (
  // pixel port
  output logic        pixel_clock,
  output logic [11:0] pixel_data,
  output logic        hsync,
  output logic        vsync
);
  initial begin
    pixel_clock = 1'b0;
    {vsync, hsync, pixel_data} = 14'h0000;
  end
  // one pixel; clock stands still between calls
  task automatic put(input logic [13:0] w, input logic fall);
    if (pixel_clock !== fall) begin
      #31 pixel_clock = fall;
    end
    {vsync, hsync, pixel_data} = w;
    #31 pixel_clock = ~pixel_clock;
    // hold over: inverse so stale data never looks valid
    #31 {vsync, hsync, pixel_data} = ~w;
    #32 pixel_clock = ~pixel_clock;
    #31;
  endtask
endmodule // spc_imager

// ---- tb/spc_top_tb_top.sv ----
// self-checking bench for the serializer pin control block
`timescale 1ns/10ps
`include "spc_defines.vh"
module spc_top_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, hsync, vsync, pixel_clock;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, v, cfg;
  logic [11:0] pixel_data;
  logic [13:0] pixel_word;
  logic [3:0]  remote_gpio, ex;
  logic [2:0]  general_output_pin, address_strap_pin;
  logic        pready, pslverr, gpo3_in, gpo3_out, gpo3_oe, scl_out, scl_oe, sda_out;
  logic        sda_oe, power_down_n, pll_enable, pixel_strobe, bscl, bsda, rerr, ack, p;
  int          fails, check_count, seed, i, k;
  logic [31:0] expq[$];
  wire scl_in = bscl & ~scl_oe;
  wire sda_in = bsda & ~sda_oe;

  spc_imager u_spc_imager (.pixel_clock(pixel_clock), .pixel_data(pixel_data),
    .hsync(hsync), .vsync(vsync));
  spc_top u_spc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pixel_clock(pixel_clock), .pixel_data(pixel_data),
    .hsync(hsync), .vsync(vsync), .remote_gpio(remote_gpio),
    .general_output_pin(general_output_pin), .gpo3_in(gpo3_in), .gpo3_out(gpo3_out),
    .gpo3_oe(gpo3_oe), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_strap_pin(address_strap_pin), .power_down_n(power_down_n),
    .pll_enable(pll_enable), .pixel_word(pixel_word), .pixel_strobe(pixel_strobe));

  always #5 pclk = ~pclk;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task tk(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no local limit: a slave that never answers is left to the watchdog
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdat, exp);
  endtask
  task i2c(input logic [6:0] a);
    bsda <= 1'b0; tk(20); bscl <= 1'b0;
    for (k = 7; k >= 0; k--) begin
      bsda <= (k > 0) ? a[k-1] : 1'b0;
      tk(20); bscl <= 1'b1; tk(20); bscl <= 1'b0;
    end
    bsda <= 1'b1; tk(20); bscl <= 1'b1; tk(10);
    ack = (sda_in === 1'b0);
    tk(10); bscl <= 1'b0; tk(20); bsda <= 1'b0; tk(20); bscl <= 1'b1; tk(20);
    bsda <= 1'b1; tk(20);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // every strobe must match a queued pixel; spare strobes fail
  always @(posedge pclk) begin
    if (presetn && pixel_strobe === 1'b1)
      chk({18'h0, pixel_word}, expq.size() ? expq.pop_front() : 32'hFFFF_FFFF);
  end
  initial begin
    #500000;
    fails++;
    give_verdict;
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hC955; pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 0; pwdata = 0; remote_gpio = 0; gpo3_in = 0; bscl = 1; bsda = 1;
    power_down_n = 1; fails = 0; check_count = 0;
    address_strap_pin = $random(seed);
    tk(12); presetn <= 1'b1; tk(4);
    rd(`SPC_ADDR_CTRL, 32'h0); rd(`SPC_ADDR_GPO_CFG, 32'h0);
    rd(`SPC_ADDR_STATUS, {24'h0, `SPC_DEV_ADDR_BASE + address_strap_pin, 1'b1});
    apb(1'b1, 8'h10, 32'hFFFF_FFFF); chk(rerr, 1);
    apb(1'b0, 8'h10, 32'h0); chk(rerr, 1); chk(rdat, 32'h0);
    for (i = 0; i < 8; i++) begin
      if (i % 4 == 0) apb(1'b1, `SPC_ADDR_CTRL, i / 4);
      v = $random(seed);
      expq.push_back({18'h0, v[13:0]});
      u_spc_imager.put(v[13:0], i / 4);
      tk(8);
    end
    chk(expq.size(), 0);
    apb(1'b1, `SPC_ADDR_PIXEL, 32'h0);
    rd(`SPC_ADDR_PIXEL, {18'h0, v[13:0]});
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      remote_gpio <= v[3:0];
      cfg = 0;
      for (k = 0; k < 4; k++) begin
        cfg[4*k +: 4] = {1'b0, v[8+k], 1'b0, v[4+k]};
        ex[k] = v[4+k] ? v[8+k] : v[k];
      end
      apb(1'b1, `SPC_ADDR_GPO_CFG, cfg); tk(5);
      chk({gpo3_oe, gpo3_out, general_output_pin}, {1'b1, ex});
      rd(`SPC_ADDR_GPO_CFG, cfg);
    end
    gpo3_in <= 1'b1;
    apb(1'b1, `SPC_ADDR_GPO_CFG, 32'h2200); tk(4);
    k = 0; p = general_output_pin[2];
    repeat (16) begin
      tk(1);
      if (general_output_pin[2] !== p) k++;
      p = general_output_pin[2];
    end
    chk(k, 4);
    chk(gpo3_oe, 0);
    apb(1'b0, `SPC_ADDR_STATUS, 32'h0); chk(rdat[8], 1);
    i2c(`SPC_DEV_ADDR_BASE + address_strap_pin); chk(ack, 1);
    i2c(`SPC_DEV_ADDR_BASE + address_strap_pin + 7'h01); chk(ack, 0);
    apb(1'b1, `SPC_ADDR_CTRL, 32'h1);
    power_down_n <= 1'b0; tk(6);
    chk({pll_enable, gpo3_oe, general_output_pin}, 0);
    apb(1'b1, `SPC_ADDR_GPO_CFG, 32'h1111);
    u_spc_imager.put(14'h1A5C, 1'b0);
    tk(1);
    power_down_n <= 1'b1; tk(6);
    chk(pll_enable, 1);
    rd(`SPC_ADDR_CTRL, 32'h0); rd(`SPC_ADDR_GPO_CFG, 32'h0);
    give_verdict;
  end
endmodule // spc_top_tb_top
